// [verilog/dmdd_pkg.sv]
// ============================================================
// Shared constants and carriers
// ============================================================
package dmdd_pkg;

    // ========================================================
    // Register offsets on the host byte I/O bus
    // ========================================================
    localparam logic [3:0] OFS_RESULT_LOW = 4'h4;
    localparam logic [3:0] OFS_RESULT_HIGH = 4'h5;
    localparam logic [3:0] OFS_DAC_LOW = 4'h4;
    localparam logic [3:0] OFS_DAC_HIGH = 4'h5;
    localparam logic [3:0] OFS_DIN_LOW = 4'h6;
    localparam logic [3:0] OFS_DIN_HIGH = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
    localparam logic [3:0] OFS_MODE = 4'hB;
    localparam logic [3:0] OFS_SOFT_TRIGGER = 4'hC;
    localparam logic [3:0] OFS_DOUT_LOW = 4'hD;
    localparam logic [3:0] OFS_DOUT_HIGH = 4'hE;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int TRIG_SEL_LSB = 0;
    localparam int IRQ_LINE_LSB = 4;
    localparam int READY_BIT_POS = 4;

    // ========================================================
    // Trigger and transfer mode codes
    // ========================================================
    localparam logic [2:0] MODE_SOFT_POLL = 3'h0;
    localparam logic [2:0] MODE_EXT_POLL = 3'h2;
    localparam logic [2:0] MODE_EXT_IRQ = 3'h3;
    localparam logic [2:0] MODE_PACER_POLL = 3'h4;
    localparam logic [2:0] MODE_PACER_IRQ = 3'h6;

    // ========================================================
    // Reset values
    // ========================================================
    localparam logic [2:0] RST_TRIG_SEL = 3'h0;
    localparam logic [2:0] RST_IRQ_LINE = 3'h0;
    localparam logic [11:0] RST_DAC_WORD = 12'h000;
    localparam logic [7:0] RST_DAC_LOW_BUF = 8'h00;
    localparam logic [15:0] RST_DOUT = 16'h0000;
    localparam logic [11:0] RST_RESULT = 12'h000;
    localparam logic RST_NOT_READY = 1'b1;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // One host bus cycle, valid for one clock
    typedef struct packed {
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] data;
    } dmdd_io_req_type;

    // Stored content of the mode register
    typedef struct packed {
        logic [2:0] irq_line;
        logic [2:0] trigger_select;
    } dmdd_mode_type;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_BUSY = 1'b1
    } dmdd_conv_state_type;

endpackage

// [verilog/dmdd_input_sync.sv]
`timescale 1ns/1ps
// ============================================================
// Two-stage synchroniser for the digital input pins
// ============================================================
module dmdd_input_sync
    import dmdd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [15:0] pin_in,
    output logic [15:0] sync_out,
    output logic bit0_rise
);

    logic [15:0] stage_one;
    logic bit0_last;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_sync
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage_one[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage_one[i] <= pin_in[i];
                    sync_out[i] <= stage_one[i];
                end
            end
        end
    endgenerate

    // Rising edge on bit 0, seen only after both stages
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit0_last <= 1'b0;
            bit0_rise <= 1'b0;
        end else begin
            bit0_last <= sync_out[0];
            bit0_rise <= sync_out[0] & ~bit0_last;
        end
    end

endmodule // dmdd_input_sync

// [verilog/dmdd_irq_router.sv]
`timescale 1ns/1ps
// ============================================================
// Steers the conversion interrupt onto one request line
// ============================================================
module dmdd_irq_router
    import dmdd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] irq_line,
    input wire logic irq_active,
    output logic [5:0] irq_request
);

    logic [5:0] next_irq_request;

    // Bit 0 is line 2, bit 5 is line 7
    always_comb begin
        next_irq_request = 6'h00;
        if (irq_active) begin
            case (irq_line)
                3'h0: next_irq_request = 6'h01;
                3'h2: next_irq_request = 6'h01;
                3'h3: next_irq_request = 6'h02;
                3'h4: next_irq_request = 6'h04;
                3'h5: next_irq_request = 6'h08;
                3'h6: next_irq_request = 6'h10;
                3'h7: next_irq_request = 6'h20;
                default: next_irq_request = 6'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_request <= 6'h00;
        end else begin
            irq_request <= next_irq_request;
        end
    end

    irq_line_map_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (irq_active && irq_line == 3'h3) |=> irq_request == 6'h02)
        else $error("line code 3 did not select request line 3");

    irq_unused_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (irq_line == 3'h1) |=> irq_request == 6'h00)
        else $error("unused line code raised a request");

endmodule // dmdd_irq_router

// [verilog/dmdd_card_ctrl.sv]
`timescale 1ns/1ps
module dmdd_card_ctrl
    import dmdd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire dmdd_io_req_type io_req,
    output logic [7:0] io_rdata,
    input wire logic [15:0] input_header,
    output logic [15:0] digital_out,
    output logic [11:0] dac_word,
    input wire logic pacer_tick,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [11:0] adc_result,
    output logic [5:0] irq_request
);

    // ========================================================
    // Decoded bus strobes
    // ========================================================
    logic wr_dac_low;
    logic wr_dac_high;
    logic wr_irq_clear;
    logic wr_mode;
    logic wr_soft_trigger;
    logic wr_dout_low;
    logic wr_dout_high;
    logic rd_result_low;
    logic rd_result_high;
    logic [3:0] wr_nibble;

    assign wr_dac_low = io_req.wr && io_req.addr == OFS_DAC_LOW;
    assign wr_dac_high = io_req.wr && io_req.addr == OFS_DAC_HIGH;
    assign wr_irq_clear = io_req.wr && io_req.addr == OFS_IRQ_CLEAR;
    assign wr_mode = io_req.wr && io_req.addr == OFS_MODE;
    assign wr_soft_trigger = io_req.wr && io_req.addr == OFS_SOFT_TRIGGER;
    assign wr_dout_low = io_req.wr && io_req.addr == OFS_DOUT_LOW;
    assign wr_dout_high = io_req.wr && io_req.addr == OFS_DOUT_HIGH;
    assign rd_result_low = io_req.rd && io_req.addr == OFS_RESULT_LOW;
    assign rd_result_high = io_req.rd && io_req.addr == OFS_RESULT_HIGH;
    assign wr_nibble = io_req.data[3:0];

    // ========================================================
    // Digital inputs
    // ========================================================
    logic [15:0] din_sync;
    logic external_trigger_rise;

    dmdd_input_sync u_input_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in(input_header),
        .sync_out(din_sync),
        .bit0_rise(external_trigger_rise)
    );

    // ========================================================
    // Mode register
    // ========================================================
    dmdd_mode_type mode;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode.trigger_select <= RST_TRIG_SEL;
            mode.irq_line <= RST_IRQ_LINE;
        end else if (wr_mode) begin
            mode.trigger_select <= io_req.data[TRIG_SEL_LSB +: 3];
            mode.irq_line <= io_req.data[IRQ_LINE_LSB +: 3];
        end
    end

    logic irq_mode;
    logic ext_mode;
    logic pacer_mode;
    logic soft_mode;

    assign irq_mode = mode.trigger_select == MODE_EXT_IRQ || mode.trigger_select == MODE_PACER_IRQ;
    assign ext_mode = mode.trigger_select == MODE_EXT_POLL || mode.trigger_select == MODE_EXT_IRQ;
    assign pacer_mode = mode.trigger_select == MODE_PACER_POLL || mode.trigger_select == MODE_PACER_IRQ;
    assign soft_mode = mode.trigger_select == MODE_SOFT_POLL;

    // ========================================================
    // Trigger selection and conversion control
    // ========================================================
    logic trigger_hit;
    dmdd_conv_state_type conv_state;

    // Unused mode codes select no source at all
    assign trigger_hit = (soft_mode && wr_soft_trigger)
        || (ext_mode && external_trigger_rise)
        || (pacer_mode && pacer_tick);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_state <= CONV_IDLE;
        end else begin
            case (conv_state)
                CONV_IDLE: begin
                    if (trigger_hit) begin
                        conv_state <= CONV_BUSY;
                    end
                end
                CONV_BUSY: begin
                    if (adc_done) begin
                        conv_state <= CONV_IDLE;
                    end
                end
                default: conv_state <= CONV_IDLE;
            endcase
        end
    end

    // One start pulse per accepted trigger; triggers while busy are dropped
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_start <= 1'b0;
        end else begin
            adc_start <= trigger_hit && conv_state == CONV_IDLE;
        end
    end

    // ========================================================
    // Result and ready bit
    // ========================================================
    logic [11:0] result;
    logic result_not_ready;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= RST_RESULT;
        end else if (adc_done) begin
            result <= adc_result;
        end
    end

    // Completion wins over a low-byte read in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_not_ready <= RST_NOT_READY;
        end else if (adc_done) begin
            result_not_ready <= 1'b0;
        end else if (rd_result_low) begin
            result_not_ready <= 1'b1;
        end
    end

    // ========================================================
    // Interrupt status flag
    // ========================================================
    logic status_flag;

    // Setting wins over a clear write in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_flag <= 1'b0;
        end else if (adc_done && irq_mode) begin
            status_flag <= 1'b1;
        end else if (wr_irq_clear) begin
            status_flag <= 1'b0;
        end
    end

    dmdd_irq_router u_irq_router (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .irq_line(mode.irq_line),
        .irq_active(status_flag && irq_mode),
        .irq_request(irq_request)
    );

    // ========================================================
    // DAC double buffer
    // ========================================================
    logic [7:0] dac_low_buf;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_low_buf <= RST_DAC_LOW_BUF;
        end else if (wr_dac_low) begin
            dac_low_buf <= io_req.data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_word <= RST_DAC_WORD;
        end else if (wr_dac_high) begin
            dac_word <= {wr_nibble, dac_low_buf};
        end
    end

    // ========================================================
    // Digital outputs
    // ========================================================
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            digital_out <= RST_DOUT;
        end else begin
            if (wr_dout_low) begin
                digital_out[7:0] <= io_req.data;
            end
            if (wr_dout_high) begin
                digital_out[15:8] <= io_req.data;
            end
        end
    end

    // ========================================================
    // Read data
    // ========================================================
    logic [7:0] next_rdata;

    // Write-only and unused offsets read as zero
    always_comb begin
        case (io_req.addr)
            OFS_RESULT_LOW: next_rdata = result[7:0];
            OFS_RESULT_HIGH: next_rdata = {3'h0, result_not_ready, result[11:8]};
            OFS_DIN_LOW: next_rdata = din_sync[7:0];
            OFS_DIN_HIGH: next_rdata = din_sync[15:8];
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            io_rdata <= RST_RDATA;
        end else if (io_req.rd) begin
            io_rdata <= next_rdata;
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    soft_trigger_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_soft_trigger && soft_mode && conv_state == CONV_IDLE) |=> adc_start ##1 !adc_start)
        else $error("software trigger write gave no single start pulse");

    start_has_source_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        adc_start |-> $past(trigger_hit) && $past(conv_state) == CONV_IDLE)
        else $error("start pulse without a selected trigger");

    external_edge_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ext_mode && external_trigger_rise && conv_state == CONV_IDLE) |=> adc_start)
        else $error("external rising edge did not start a conversion");

    done_ready_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        adc_done |=> !result_not_ready)
        else $error("ready bit not low after completion");

    low_read_ready_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_result_low && !adc_done) |=> result_not_ready)
        else $error("low byte read did not set ready bit");

    flag_set_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (adc_done && irq_mode) |=> status_flag)
        else $error("completion in interrupt mode left flag clear");

    flag_clear_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_irq_clear && !adc_done) |=> !status_flag ##1 (irq_request == 6'h00))
        else $error("clear write did not drop flag and request");

    dac_low_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_dac_low && !wr_dac_high) |=> $stable(dac_word))
        else $error("DAC output moved on a low byte write");

    dac_high_update_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_dac_high |=> dac_word[11:8] == $past(wr_nibble) && dac_word[7:0] == $past(dac_low_buf))
        else $error("DAC word not loaded from high write and buffer");

    high_read_format_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rd_result_high |=> io_rdata[7:5] == 3'h0 && io_rdata[4] == $past(result_not_ready))
        else $error("result high byte format wrong");

    mode_read_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (io_req.rd && io_req.addr == OFS_MODE) |=> io_rdata == 8'h00)
        else $error("mode register was readable");

    polled_no_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!irq_mode) [*2] |-> irq_request == 6'h00)
        else $error("request raised in a polled mode");

endmodule // dmdd_card_ctrl

// [testbench/dmdd_conv_model.sv]
`timescale 1ns/1ps
// ============================================================
// Converter stand-in: answers a start pulse after a short or long delay
// ============================================================
module dmdd_conv_model
    import dmdd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic adc_start,
    input wire logic slow,
    input wire logic [11:0] conv_value,
    output logic adc_done,
    output logic [11:0] adc_result
);
    int remain;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            remain <= 0;
            adc_done <= 1'b0;
        end else begin
            adc_done <= (remain == 1);
            if (adc_start) begin
                remain <= slow ? 20 : 2;
            end else if (remain > 0) begin
                remain <= remain - 1;
            end
        end
    end

    // Result is only valid with done; otherwise the lines carry junk
    assign adc_result = adc_done ? conv_value : ~conv_value;
endmodule // dmdd_conv_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import dmdd_pkg::*;
;
    logic sys_clk;
    logic reset_n;
    dmdd_io_req_type io_req;
    logic [7:0] io_rdata;
    logic [15:0] input_header;
    logic [15:0] digital_out;
    logic [11:0] dac_word;
    logic pacer_tick;
    logic adc_start;
    logic adc_done;
    logic [11:0] adc_result;
    logic [5:0] irq_request;
    logic slow;
    logic [11:0] conv_value;
    logic [7:0] rd_val;
    logic [5:0] exp_irq;
    logic fire;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int done_cnt = 0;

    dmdd_card_ctrl i_dmdd_card_ctrl (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .io_req(io_req),
        .io_rdata(io_rdata),
        .input_header(input_header),
        .digital_out(digital_out),
        .dac_word(dac_word),
        .pacer_tick(pacer_tick),
        .adc_start(adc_start),
        .adc_done(adc_done),
        .adc_result(adc_result),
        .irq_request(irq_request)
    );

    dmdd_conv_model i_dmdd_conv_model (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .adc_start(adc_start),
        .slow(slow),
        .conv_value(conv_value),
        .adc_done(adc_done),
        .adc_result(adc_result)
    );

    // ============================================================
    // Clock, cycle ceiling and event counting
    // ============================================================
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (adc_done === 1'b1) begin
            done_cnt++;
        end
        if (cyc == 10000) begin
            error_cnt++;
            $display("mismatch timeout expected finish seen hang");
            complete_run;
        end
    end

    // ============================================================
    // Tasks
    // ============================================================
    task automatic complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        io_req = '{addr: a, wr: 1'b1, rd: 1'b0, data: d};
        @(negedge sys_clk);
        io_req.wr = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic bus_rd(input logic [3:0] a);
        io_req = '{addr: a, wr: 1'b0, rd: 1'b1, data: 8'h00};
        @(negedge sys_clk);
        rd_val = io_rdata;
        io_req.rd = 1'b0;
        @(negedge sys_clk);
    endtask

    // Source 0 software write, 1 external edge, 2 pacer tick
    task automatic convert(input int src, input logic fires);
        int mark;
        int n;
        mark = done_cnt;
        n = 0;
        case (src)
            0: bus_wr(OFS_SOFT_TRIGGER, 8'h5A);
            1: begin
                input_header[0] = 1'b1;
                idle(1);
            end
            default: begin
                pacer_tick = 1'b1;
                idle(1);
                pacer_tick = 1'b0;
            end
        endcase
        while (done_cnt == mark && n < 40) begin
            idle(1);
            n++;
        end
        chk("conversions", {15'h0, fires}, 16'(done_cnt - mark));
        idle(3);
        input_header[0] = 1'b0;
        idle(4);
    endtask

    // ============================================================
    // Test sequence
    // ============================================================
    initial begin
        reset_n = 1'b0;
        io_req = '0;
        input_header = 16'h0000;
        pacer_tick = 1'b0;
        slow = 1'b1;
        conv_value = 12'hABC;
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        chk("dac_word", 16'h0000, {4'h0, dac_word});
        chk("irq_request", 16'h0000, {10'h0, irq_request});
        bus_rd(OFS_RESULT_HIGH);
        chk("result high", 16'h0010, {8'h00, rd_val});
        bus_wr(OFS_DAC_LOW, 8'hA5);
        chk("dac_word", 16'h0000, {4'h0, dac_word});
        bus_wr(OFS_DAC_HIGH, 8'hF3);
        chk("dac_word", 16'h03A5, {4'h0, dac_word});
        bus_wr(OFS_DAC_HIGH, 8'h0C);
        chk("dac_word", 16'h0CA5, {4'h0, dac_word});
        bus_wr(OFS_DOUT_LOW, 8'h5A);
        bus_wr(OFS_DOUT_HIGH, 8'hC3);
        chk("digital_out", 16'hC35A, digital_out);
        input_header = 16'h8E34;
        idle(3);
        bus_rd(OFS_DIN_LOW);
        chk("input low", 16'h0034, {8'h00, rd_val});
        bus_rd(OFS_DIN_HIGH);
        chk("input high", 16'h008E, {8'h00, rd_val});
        for (int a = 8; a < 16; a++) begin
            bus_rd(4'(a));
            chk("write-only read", 16'h0000, {8'h00, rd_val});
        end
        input_header = 16'h0000;
        idle(3);
        convert(0, 1'b1);
        bus_rd(OFS_RESULT_HIGH);
        chk("result high", 16'h000A, {8'h00, rd_val});
        bus_rd(OFS_RESULT_LOW);
        chk("result low", 16'h00BC, {8'h00, rd_val});
        bus_rd(OFS_RESULT_HIGH);
        chk("result high", 16'h001A, {8'h00, rd_val});
        // Every mode code against every trigger source
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 3; s++) begin
                fire = (c == 0 && s == 0) || ((c == 2 || c == 3) && s == 1) || ((c == 4 || c == 6) && s == 2);
                slow = c[0];
                bus_wr(OFS_MODE, 8'h88 | 8'(c));
                convert(s, fire);
                chk("irq_request", {15'h0, fire && (c == 3 || c == 6)}, {10'h0, irq_request});
                bus_wr(OFS_IRQ_CLEAR, 8'hFF);
            end
        end
        // Every interrupt line code
        for (int l = 0; l < 8; l++) begin
            exp_irq = (l == 0 || l == 2) ? 6'h01 : (l == 1) ? 6'h00 : 6'(1 << (l - 2));
            bus_wr(OFS_MODE, {1'b0, 3'(l), 1'b0, MODE_EXT_IRQ});
            convert(1, 1'b1);
            idle(10);
            chk("irq_request", {10'h0, exp_irq}, {10'h0, irq_request});
            bus_wr(OFS_IRQ_CLEAR, 8'(l));
            idle(2);
            chk("irq_request", 16'h0000, {10'h0, irq_request});
        end
        complete_run;
    end
endmodule // tb_top
